// >>> arc_pkg.sv
package arc_pkg;

  // ----------------------------------------------------------------
  // Coefficient page offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ARC_TEMP_OFFSET_COEF_ADDR = 8'h4A;
  localparam logic [7:0] ARC_VOLT_COEF_ADDR        = 8'h4C;
  localparam logic [7:0] ARC_BIAS_COEF_ADDR        = 8'h50;
  localparam logic [7:0] ARC_TX_COEF_ADDR          = 8'h54;
  localparam logic [7:0] ARC_RX_COEF_ADDR          = 8'h28;
  localparam logic [7:0] ARC_DELIM_ADDR            = 8'hD0;
  localparam logic [7:0] ARC_OEM_CONFIG_ONE_ADDR   = 8'hE1;
  localparam logic [7:0] ARC_OEM_CONFIG_THREE_ADDR = 8'hE3;
  localparam logic [7:0] ARC_OEM_CONFIG_SIX_ADDR   = 8'hE6;

  // ----------------------------------------------------------------
  // Result page offsets, high byte at the even address
  // ----------------------------------------------------------------
  localparam logic [7:0] ARC_TEMP_RESULT_ADDR = 8'h60;
  localparam logic [7:0] ARC_VOLT_RESULT_ADDR = 8'h62;
  localparam logic [7:0] ARC_BIAS_RESULT_ADDR = 8'h64;
  localparam logic [7:0] ARC_TX_RESULT_ADDR   = 8'h66;
  localparam logic [7:0] ARC_RX_RESULT_ADDR   = 8'h68;

  // ----------------------------------------------------------------
  // Fields, reset values, counts
  // ----------------------------------------------------------------
  localparam int         ARC_CAL_SEL_BIT   = 0;
  localparam int         ARC_PD_REF_BIT    = 0;
  localparam int         ARC_DELIM_SEL_LSB = 5;
  localparam logic [1:0] ARC_DELIM_PROG    = 2'h1;
  localparam logic [7:0] ARC_CONFIG_RST    = 8'h00;
  localparam logic [3:0] ARC_COEF_BYTES    = 4'h4;
  localparam logic [3:0] ARC_TOFF_BYTES    = 4'h1;
  localparam logic [3:0] ARC_DELIM_BYTES   = 4'hE;
  localparam logic [6:0][15:0] ARC_FIXED_DELIM = {16'hE000, 16'hC000, 16'hA000,
    16'h8000, 16'h6000, 16'h4000, 16'h2000};

  typedef enum logic [2:0] {
    ARC_CH_TEMP = 3'h0,
    ARC_CH_VOLT = 3'h1,
    ARC_CH_BIAS = 3'h2,
    ARC_CH_TX   = 3'h3,
    ARC_CH_RX   = 3'h4
  } arc_chan_t;

  typedef enum logic [2:0] {
    ARC_S_IDLE  = 3'h0,
    ARC_S_FETCH = 3'h1,
    ARC_S_PICK  = 3'h2,
    ARC_S_MATH  = 3'h3,
    ARC_S_WAIT  = 3'h4,
    ARC_S_WRITE = 3'h5
  } arc_state_t;

endpackage : arc_pkg

// >>> arc_coef_mem.sv
`timescale 1ns/1ps
module arc_coef_mem #(
  parameter int AW = 8
) (
  input  wire logic          ref_clk,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic          a_we,
  input  wire logic [7:0]    a_wdata,
  output logic      [7:0]    a_rdata,
  input  wire logic [AW-1:0] b_addr,
  output logic      [7:0]    b_rdata
);

  logic [7:0] mem [2**AW];

  // Stand-in for the nonvolatile array; contents are not reset
  always_ff @(posedge ref_clk)
  begin
    if (a_we)
    begin
      mem[a_addr] <= a_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end

endmodule : arc_coef_mem

// >>> arc_cal_math.sv
`timescale 1ns/1ps
module arc_cal_math
  import arc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        start,
  input  wire logic [15:0] raw,
  input  wire logic [15:0] slope,
  input  wire logic [15:0] offset,
  output logic      [15:0] result,
  output logic             done
);

  logic [31:0] prod;
  logic [32:0] sum;

  // Slope carries eight fraction bits; offset shares the result weight
  assign prod = raw * slope;
  assign sum  = {1'b0, prod} + {{9{offset[15]}}, offset, 8'h00};

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      result <= 16'h0000;
      done   <= 1'b0;
    end
    else
    begin
      done <= start;
      if (start)
      begin
        result <= sum[23:8] + {15'h0000, sum[7]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic signed [40:0] exp_full;
  // Operands widened first so the reference product cannot wrap
  assign exp_full = $signed({25'h0, raw}) * $signed({25'h0, slope})
                    + ($signed(offset) * 41'sd256) + 41'sd128;

  property p_round;
    @(posedge ref_clk) disable iff (srst)
    start |=> done && result == $past(exp_full[23:8]);
  endproperty
  a_round: assert property (p_round) else $error("rounded result wrong");

endmodule : arc_cal_math

// >>> arc_calibrator.sv
// Operation
// - Reset selects external calibration; select bit 0 of config three picks internal.
// - Temperature and voltage always report internally calibrated format; in external mode voltage is stored raw, without slope or offset.
// - Six-bit signed temperature offset at 4Ah added, half degree per step.
// - Temperature offset applies the same in both calibration modes.
// - Upper two bits of temperature offset byte ignored.
// - Temperature offset spans -32 to +31 half-degree steps.
// - External bias result is eight-bit code in upper byte, low byte zero.
// - External transmit power is eight-bit code in upper byte, low byte zero.
// - Config one bit selects photodiode reference, ground or analog supply.
// - Receive power reported as upper and lower byte, 16-bit weighted.
// - Internal mode corrects each conversion before storing it.
// - Internal mode: slope and offset for four channels, offset only temperature.
// - Receive power corrected piecewise over eight intervals with own coefficients.
// - Config six bits 6:5 pick fixed or programmable delimiters at 208-221.
// - Slope is unsigned 16-bit, eight fraction bits.
// - Two-byte coefficients: high byte at lower address.
// - Offsets are signed 16-bit with result weight.
// - Corrected result is conversion times slope plus offset.
// - Round to sixteen bits using the next lower bit.
// - Receive interval: lower delimiter below value, upper at or above.
`timescale 1ns/1ps
module arc_calibrator
  import arc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        conv_valid,
  input  wire logic [2:0]  conv_channel,
  input  wire logic [15:0] conv_data,
  output logic             conv_ready,
  input  wire logic        mgmt_page,
  input  wire logic [7:0]  mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [7:0]  mgmt_wdata,
  output logic      [7:0]  mgmt_rdata,
  output logic             mgmt_rvalid,
  output logic             internal_cal_select,
  output logic             photodiode_ref_select,
  output logic             result_update
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] arc_interval(input logic [15:0] v,
                                              input logic [6:0][15:0] d);
    logic [2:0] m;
    m = 3'h0;
    for (int i = 0; i < 7; i++)
    begin
      if (v > d[i])
      begin
        m = 3'(i + 1);
      end
    end
    return m;
  endfunction : arc_interval

  function automatic logic [7:0] arc_coef_base(input logic [2:0] ch);
    case (ch)
      ARC_CH_VOLT: return ARC_VOLT_COEF_ADDR;
      ARC_CH_BIAS: return ARC_BIAS_COEF_ADDR;
      default:     return ARC_TX_COEF_ADDR;
    endcase
  endfunction : arc_coef_base

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  arc_state_t          state_reg;
  logic [2:0]          chan_reg;
  logic [15:0]         raw_reg;
  logic                mode_reg;
  logic                dlm_phase_reg;
  logic [7:0]          fetch_base_reg;
  logic [3:0]          fetch_len_reg;
  logic [3:0]          fetch_cnt_reg;
  logic [111:0]        buf_reg;
  logic [6:0][15:0]    delim_reg;
  logic [7:0]          cfg1_reg;
  logic [7:0]          cfg3_reg;
  logic [7:0]          cfg6_reg;
  logic [15:0]         temp_res_reg;
  logic [15:0]         volt_res_reg;
  logic [15:0]         bias_res_reg;
  logic [15:0]         tx_res_reg;
  logic [15:0]         rx_res_reg;
  logic                rd_p_reg;
  logic                page_p_reg;
  logic [7:0]          addr_p_reg;
  logic [7:0]          ram_a_rdata;
  logic [7:0]          ram_b_rdata;
  logic [7:0]          ram_b_addr;
  logic                accept;
  logic                fetch_last;
  logic                cfg_wr;
  logic                math_start;
  logic                math_done;
  logic [15:0]         math_result;
  logic [15:0]         toff_ext;
  logic [15:0]         wr_val;
  logic [2:0]          pick_m;

  assign accept     = conv_valid && conv_ready;
  assign fetch_last = (fetch_cnt_reg == fetch_len_reg);
  assign cfg_wr     = mgmt_wr && mgmt_page;
  assign ram_b_addr = fetch_base_reg + {4'h0, fetch_cnt_reg};
  assign math_start = (state_reg == ARC_S_MATH);
  assign pick_m     = arc_interval(raw_reg, delim_reg);
  // Upper two bits dropped; one step is 128 counts of 1/256 degree
  assign toff_ext   = {{3{buf_reg[5]}}, buf_reg[5:0], 7'h00};

  assign internal_cal_select   = cfg3_reg[ARC_CAL_SEL_BIT];
  assign photodiode_ref_select = cfg1_reg[ARC_PD_REF_BIT];

  arc_coef_mem #(
    .AW (8)
  ) u_mem (
    .ref_clk (ref_clk),
    .a_addr  (mgmt_addr),
    .a_we    (cfg_wr),
    .a_wdata (mgmt_wdata),
    .a_rdata (ram_a_rdata),
    .b_addr  (ram_b_addr),
    .b_rdata (ram_b_rdata)
  );

  arc_cal_math u_math (
    .ref_clk (ref_clk),
    .srst    (srst),
    .start   (math_start),
    .raw     (raw_reg),
    .slope   (buf_reg[31:16]),
    .offset  (buf_reg[15:0]),
    .result  (math_result),
    .done    (math_done)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cfg1_reg <= ARC_CONFIG_RST;
      cfg3_reg <= ARC_CONFIG_RST;
      cfg6_reg <= ARC_CONFIG_RST;
    end
    else if (cfg_wr)
    begin
      if (mgmt_addr == ARC_OEM_CONFIG_ONE_ADDR)
        cfg1_reg <= mgmt_wdata;
      if (mgmt_addr == ARC_OEM_CONFIG_THREE_ADDR)
        cfg3_reg <= mgmt_wdata;
      if (mgmt_addr == ARC_OEM_CONFIG_SIX_ADDR)
        cfg6_reg <= mgmt_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg      <= ARC_S_IDLE;
      chan_reg       <= 3'h0;
      raw_reg        <= 16'h0000;
      mode_reg       <= 1'b0;
      dlm_phase_reg  <= 1'b0;
      fetch_base_reg <= 8'h00;
      fetch_len_reg  <= 4'h0;
      fetch_cnt_reg  <= 4'h0;
      delim_reg      <= ARC_FIXED_DELIM;
    end
    else
    begin
      case (state_reg)
        ARC_S_IDLE:
        begin
          fetch_cnt_reg <= 4'h0;
          if (accept)
          begin
            chan_reg <= conv_channel;
            // Bias and transmit codes are eight bits wide
            raw_reg  <= (conv_channel == ARC_CH_BIAS || conv_channel == ARC_CH_TX)
                        ? {8'h00, conv_data[7:0]} : conv_data;
            // Mode frozen per conversion so no result mixes modes
            mode_reg <= internal_cal_select;
            dlm_phase_reg <= 1'b0;
            if (conv_channel == ARC_CH_TEMP)
            begin
              fetch_base_reg <= ARC_TEMP_OFFSET_COEF_ADDR;
              fetch_len_reg  <= ARC_TOFF_BYTES;
              state_reg      <= ARC_S_FETCH;
            end
            else if (!internal_cal_select)
              state_reg <= ARC_S_WRITE;
            else if (conv_channel == ARC_CH_RX)
            begin
              if (cfg6_reg[ARC_DELIM_SEL_LSB +: 2] == ARC_DELIM_PROG)
              begin
                fetch_base_reg <= ARC_DELIM_ADDR;
                fetch_len_reg  <= ARC_DELIM_BYTES;
                dlm_phase_reg  <= 1'b1;
                state_reg      <= ARC_S_FETCH;
              end
              else
              begin
                delim_reg <= ARC_FIXED_DELIM;
                state_reg <= ARC_S_PICK;
              end
            end
            else
            begin
              fetch_base_reg <= arc_coef_base(conv_channel);
              fetch_len_reg  <= ARC_COEF_BYTES;
              state_reg      <= ARC_S_FETCH;
            end
          end
        end
        ARC_S_FETCH:
        begin
          fetch_cnt_reg <= fetch_cnt_reg + 4'h1;
          if (fetch_last)
          begin
            if (dlm_phase_reg)
            begin
              delim_reg     <= {buf_reg[7:0], ram_b_rdata, buf_reg[111:16]
                               & 96'h0} | delim_pack(buf_reg, ram_b_rdata);
              state_reg     <= ARC_S_PICK;
            end
            else if (chan_reg == ARC_CH_TEMP)
              state_reg <= ARC_S_WRITE;
            else
              state_reg <= ARC_S_MATH;
          end
        end
        ARC_S_PICK:
        begin
          fetch_base_reg <= ARC_RX_COEF_ADDR + {3'h0, pick_m, 2'h0};
          fetch_len_reg  <= ARC_COEF_BYTES;
          fetch_cnt_reg  <= 4'h0;
          dlm_phase_reg  <= 1'b0;
          state_reg      <= ARC_S_FETCH;
        end
        ARC_S_MATH:
          state_reg <= ARC_S_WAIT;
        ARC_S_WAIT:
          if (math_done)
            state_reg <= ARC_S_WRITE;
        ARC_S_WRITE:
          state_reg <= ARC_S_IDLE;
        default:
          state_reg <= ARC_S_IDLE;
      endcase
    end
  end

  // First delimiter sits at the lowest address, high byte first
  function automatic logic [6:0][15:0] delim_pack(input logic [111:0] b,
                                                  input logic [7:0] last);
    logic [111:0] all;
    all = {b[103:0], last};
    for (int i = 0; i < 7; i++)
    begin
      delim_pack[i] = all[111 - 16*i -: 16];
    end
  endfunction : delim_pack

  // Byte gatherer; oldest byte ends up most significant
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      buf_reg <= '0;
    else if (state_reg == ARC_S_FETCH && fetch_cnt_reg != 4'h0)
      buf_reg <= {buf_reg[103:0], ram_b_rdata};
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always_comb
  begin
    if (chan_reg == ARC_CH_TEMP)
      wr_val = raw_reg + toff_ext;
    else if (mode_reg)
      wr_val = math_result;
    else if (chan_reg == ARC_CH_BIAS || chan_reg == ARC_CH_TX)
      wr_val = {raw_reg[7:0], 8'h00};
    else
      wr_val = raw_reg;
  end

  // Whole word lands in one edge, never half updated
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      temp_res_reg  <= 16'h0000;
      volt_res_reg  <= 16'h0000;
      bias_res_reg  <= 16'h0000;
      tx_res_reg    <= 16'h0000;
      rx_res_reg    <= 16'h0000;
      result_update <= 1'b0;
    end
    else
    begin
      result_update <= (state_reg == ARC_S_WRITE);
      if (state_reg == ARC_S_WRITE)
      begin
        case (chan_reg)
          ARC_CH_TEMP: temp_res_reg <= wr_val;
          ARC_CH_VOLT: volt_res_reg <= wr_val;
          ARC_CH_BIAS: bias_res_reg <= wr_val;
          ARC_CH_TX:   tx_res_reg   <= wr_val;
          default:     rx_res_reg   <= wr_val;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      conv_ready <= 1'b1;
    else if (accept)
      conv_ready <= 1'b0;
    else if (state_reg == ARC_S_WRITE)
      conv_ready <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Management read path, two-cycle latency
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rd_p_reg    <= 1'b0;
      page_p_reg  <= 1'b0;
      addr_p_reg  <= 8'h00;
      mgmt_rdata  <= 8'h00;
      mgmt_rvalid <= 1'b0;
    end
    else
    begin
      rd_p_reg    <= mgmt_rd;
      page_p_reg  <= mgmt_page;
      addr_p_reg  <= mgmt_addr;
      mgmt_rvalid <= rd_p_reg;
      if (rd_p_reg)
      begin
        if (page_p_reg)
        begin
          case (addr_p_reg)
            ARC_OEM_CONFIG_ONE_ADDR:   mgmt_rdata <= cfg1_reg;
            ARC_OEM_CONFIG_THREE_ADDR: mgmt_rdata <= cfg3_reg;
            ARC_OEM_CONFIG_SIX_ADDR:   mgmt_rdata <= cfg6_reg;
            default:                   mgmt_rdata <= ram_a_rdata;
          endcase
        end
        else
        begin
          case (addr_p_reg)
            ARC_TEMP_RESULT_ADDR:        mgmt_rdata <= temp_res_reg[15:8];
            ARC_TEMP_RESULT_ADDR + 8'h1: mgmt_rdata <= temp_res_reg[7:0];
            ARC_VOLT_RESULT_ADDR:        mgmt_rdata <= volt_res_reg[15:8];
            ARC_VOLT_RESULT_ADDR + 8'h1: mgmt_rdata <= volt_res_reg[7:0];
            ARC_BIAS_RESULT_ADDR:        mgmt_rdata <= bias_res_reg[15:8];
            ARC_BIAS_RESULT_ADDR + 8'h1: mgmt_rdata <= bias_res_reg[7:0];
            ARC_TX_RESULT_ADDR:          mgmt_rdata <= tx_res_reg[15:8];
            ARC_TX_RESULT_ADDR + 8'h1:   mgmt_rdata <= tx_res_reg[7:0];
            ARC_RX_RESULT_ADDR:          mgmt_rdata <= rx_res_reg[15:8];
            ARC_RX_RESULT_ADDR + 8'h1:   mgmt_rdata <= rx_res_reg[7:0];
            default:                     mgmt_rdata <= 8'h00;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  logic wr_now;
  assign wr_now = (state_reg == ARC_S_WRITE);

  property p_reset_mode;
    @(posedge ref_clk) disable iff (1'b0)
    srst |=> !internal_cal_select;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("not external after reset");

  property p_mode_write;
    cfg_wr && mgmt_addr == ARC_OEM_CONFIG_THREE_ADDR
      |=> internal_cal_select == $past(mgmt_wdata[ARC_CAL_SEL_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode bit not taken");

  property p_pd_ref;
    cfg_wr && mgmt_addr == ARC_OEM_CONFIG_ONE_ADDR
      |=> photodiode_ref_select == $past(mgmt_wdata[ARC_PD_REF_BIT]);
  endproperty
  a_pd_ref: assert property (p_pd_ref) else $error("reference select wrong");

  property p_temp_offset;
    wr_now && chan_reg == ARC_CH_TEMP
      |=> temp_res_reg == $past(raw_reg) + {{3{$past(buf_reg[5])}},
          $past(buf_reg[5:0]), 7'h00};
  endproperty
  a_temp_offset: assert property (p_temp_offset) else $error("temp offset wrong");

  property p_ext_bias;
    wr_now && !mode_reg && chan_reg == ARC_CH_BIAS
      |=> bias_res_reg[7:0] == 8'h00 && bias_res_reg[15:8] == $past(raw_reg[7:0]);
  endproperty
  a_ext_bias: assert property (p_ext_bias) else $error("external bias wrong");

  property p_ext_tx;
    wr_now && !mode_reg && chan_reg == ARC_CH_TX |=> tx_res_reg[7:0] == 8'h00;
  endproperty
  a_ext_tx: assert property (p_ext_tx) else $error("external tx low byte");

  property p_atomic;
    !$stable(temp_res_reg) || !$stable(volt_res_reg) || !$stable(bias_res_reg)
      || !$stable(tx_res_reg) || !$stable(rx_res_reg) |-> $past(wr_now);
  endproperty
  a_atomic: assert property (p_atomic) else $error("result changed outside write");

  property p_interval;
    state_reg == ARC_S_PICK |->
      (pick_m == 3'h0 || raw_reg > delim_reg[pick_m - 3'h1])
      && (pick_m == 3'h7 || raw_reg <= delim_reg[pick_m]);
  endproperty
  a_interval: assert property (p_interval) else $error("wrong rx interval");

  property p_fixed_delim;
    accept && internal_cal_select && conv_channel == ARC_CH_RX
      && cfg6_reg[ARC_DELIM_SEL_LSB +: 2] != ARC_DELIM_PROG
      |=> state_reg == ARC_S_PICK ##1 state_reg == ARC_S_FETCH ##[1:12]
      state_reg == ARC_S_WRITE;
  endproperty
  a_fixed_delim: assert property (p_fixed_delim) else $error("fixed path wrong");

  property p_int_write;
    wr_now && mode_reg && chan_reg != ARC_CH_TEMP |-> $past(math_done);
  endproperty
  a_int_write: assert property (p_int_write) else $error("uncorrected write");

  c_temp:   cover property (wr_now && chan_reg == ARC_CH_TEMP);
  c_rx_int: cover property (wr_now && mode_reg && chan_reg == ARC_CH_RX);
  c_ext:    cover property (wr_now && !mode_reg && chan_reg == ARC_CH_BIAS);
  c_prog:   cover property (state_reg == ARC_S_PICK && $past(dlm_phase_reg));

endmodule : arc_calibrator

// >>> arc_host_model.sv
`timescale 1ns/1ps
module arc_host_model (
  input  wire logic       ref_clk,
  output logic            mgmt_page,
  output logic [7:0]      mgmt_addr,
  output logic            mgmt_wr,
  output logic            mgmt_rd,
  output logic [7:0]      mgmt_wdata,
  input  wire logic [7:0] mgmt_rdata,
  input  wire logic       mgmt_rvalid
);
  initial
  begin
    {mgmt_page, mgmt_addr, mgmt_wr, mgmt_rd, mgmt_wdata} = 19'h0;
  end

  task automatic wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {mgmt_page, mgmt_addr, mgmt_wdata, mgmt_wr} = {pg, a, d, 1'b1};
    @(negedge ref_clk);
    mgmt_wr = 1'b0;
  endtask : wr

  // Coefficients go in before internal results are trusted
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(1'b1, a, v[15:8]);
    wr(1'b1, a + 8'h01, v[7:0]);
  endtask : wr16

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge ref_clk);
    {mgmt_page, mgmt_addr, mgmt_rd} = {1'b0, a, 1'b1};
    @(negedge ref_clk);
    mgmt_rd = 1'b0;
    n = 0;
    while (mgmt_rvalid !== 1'b1 && n < 8)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // A missing answer hands back unknowns so the caller's compare trips
    d = (mgmt_rvalid === 1'b1) ? mgmt_rdata : 8'hXX;
  endtask : rd

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 8'h01, v[7:0]);
  endtask : rd16
endmodule : arc_host_model

// >>> adc_result_calibration_tb.sv
`timescale 1ns/1ps
module adc_result_calibration_tb;
  import arc_pkg::*;
  typedef struct packed {logic [2:0] ch; logic [15:0] raw; logic [15:0] exp;} arc_row_t;
  logic        ref_clk, srst, conv_valid, conv_ready, result_update;
  logic [2:0]  conv_channel;
  logic [15:0] conv_data, got;
  logic        mgmt_page, mgmt_wr, mgmt_rd, mgmt_rvalid;
  logic [7:0]  mgmt_addr, mgmt_wdata, mgmt_rdata;
  logic        internal_cal_select, photodiode_ref_select;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  // Offset byte FF: top bits dropped, so -1 step on temperature
  arc_row_t rows [5] = '{'{3'h0, 16'h1000, 16'h0F80}, '{3'h1, 16'h1234, 16'h1234},
    '{3'h2, 16'hAB55, 16'h5500}, '{3'h3, 16'h00FF, 16'hFF00}, '{3'h4, 16'hBEEF, 16'hBEEF}};

  arc_calibrator i_dut (.ref_clk(ref_clk), .srst(srst), .conv_valid(conv_valid),
    .conv_channel(conv_channel), .conv_data(conv_data), .conv_ready(conv_ready),
    .mgmt_page(mgmt_page), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .internal_cal_select(internal_cal_select),
    .photodiode_ref_select(photodiode_ref_select), .result_update(result_update));
  arc_host_model i_host (.ref_clk(ref_clk), .mgmt_page(mgmt_page), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // Hang guard, well above the expected few hundred cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      $display("CHECK FAILED cycle_limit expected %0d seen %0d", 2999, cyc);
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] act);
    checked++;
    if (act !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
    end
  endtask : chk

  task automatic conv(input logic [2:0] ch, input logic [15:0] raw, output logic [15:0] res);
    int n;
    @(negedge ref_clk);
    {conv_valid, conv_channel, conv_data} = {1'b1, ch, raw};
    @(negedge ref_clk);
    conv_valid = 1'b0;
    chk("conv_ready_busy", 16'h0000, conv_ready);
    n = 0;
    while (result_update !== 1'b1 && n < 60)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("conv_done", 16'h0001, result_update);
    chk("conv_ready_idle", 16'h0001, conv_ready);
    i_host.rd16(ARC_TEMP_RESULT_ADDR + {4'h0, ch, 1'b0}, res);
  endtask : conv

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {srst, conv_valid, conv_channel, conv_data} = {1'b1, 20'h0};
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    chk("cal_select_reset", 16'h0000, internal_cal_select);
    chk("ready_reset", 16'h0001, conv_ready);
    i_host.rd16(ARC_VOLT_RESULT_ADDR, got);
    chk("volt_reset", 16'h0000, got);
    i_host.wr(1'b1, ARC_OEM_CONFIG_ONE_ADDR, 8'h01);
    i_host.wr(1'b1, ARC_TEMP_OFFSET_COEF_ADDR, 8'hFF);
    chk("pd_ref", 16'h0001, photodiode_ref_select);
    i_host.wr16(ARC_VOLT_COEF_ADDR, 16'h0100);
    i_host.wr16(ARC_VOLT_COEF_ADDR + 8'h02, 16'h0000);
    foreach (rows[i])
    begin
      conv(rows[i].ch, rows[i].raw, got);
      chk("ext_row", rows[i].exp, got);
    end
    // Result page is read-only from the host side
    i_host.wr(1'b0, ARC_VOLT_RESULT_ADDR, 8'hAA);
    i_host.rd16(ARC_VOLT_RESULT_ADDR, got);
    chk("page0_write", 16'h1234, got);
    i_host.wr(1'b1, ARC_TEMP_OFFSET_COEF_ADDR, 8'h1F);
    conv(3'h0, 16'h1000, got);
    chk("toff_max", 16'h1F80, got);
    i_host.wr(1'b1, ARC_TEMP_OFFSET_COEF_ADDR, 8'hE0);
    // ----------------------------------------------------------------
    // Internal calibration
    // ----------------------------------------------------------------
    i_host.wr16(ARC_VOLT_COEF_ADDR, 16'h0180);
    i_host.wr16(ARC_VOLT_COEF_ADDR + 8'h02, 16'hFFFF);
    i_host.wr(1'b1, ARC_OEM_CONFIG_THREE_ADDR, 8'h01);
    for (int i = 0; i < 4; i++)
      i_host.wr16(ARC_RX_COEF_ADDR + 8'(2 * i), (i == 3) ? 16'h0010 : {7'h0, ~i[0], 8'h0});
    chk("cal_select_set", 16'h0001, internal_cal_select);
    conv(3'h1, 16'h0003, got);
    chk("volt_round", 16'h0004, got);
    conv(3'h4, 16'h2000, got);
    chk("rx_at_delim", 16'h2000, got);
    conv(3'h4, 16'h2001, got);
    chk("rx_above_delim", 16'h2011, got);
    conv(3'h0, 16'h2000, got);
    chk("toff_min_int", 16'h1000, got);
    // Transmit code is eight bits; slope two, offset five
    i_host.wr16(ARC_TX_COEF_ADDR, 16'h0200);
    i_host.wr16(ARC_TX_COEF_ADDR + 8'h02, 16'h0005);
    conv(3'h3, 16'hAAFF, got);
    chk("tx_int", 16'h0203, got);
    for (int i = 0; i < 7; i++)
      i_host.wr16(ARC_DELIM_ADDR + 8'(2 * i), 16'h1000 + 16'(i) * 16'h2000);
    i_host.wr(1'b1, ARC_OEM_CONFIG_SIX_ADDR, 8'h20);
    conv(3'h4, 16'h1001, got);
    chk("rx_prog_delim", 16'h1011, got);
    // Mid-run reset clears mode and results
    @(negedge ref_clk);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    chk("cal_select_rst2", 16'h0000, internal_cal_select);
    chk("ready_rst2", 16'h0001, conv_ready);
    i_host.rd16(ARC_RX_RESULT_ADDR, got);
    chk("rx_rst2", 16'h0000, got);
    wrap_up();
  end
endmodule : adc_result_calibration_tb
